// file: sim/mqp_regs_props.sv
// Assertion checker for the queue pointer register bank.
`timescale 1ns/1ns
module mqp_regs_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire mqp_pkg::mqp_req_t host_req,
    input wire logic [31:0] host_rdata,
    input wire mqp_pkg::mqp_req_t local_req,
    input wire logic [31:0] local_rdata,
    input wire logic [31:0] queue_base,
    input wire logic [4:0] queue_size,
    input wire mqp_pkg::mqp_step_t step,
    input wire mqp_pkg::mqp_addr_t qaddr,
    input wire logic [mqp_pkg::PTR_W-1:0] in_post_tail_ptr,
    input wire logic [mqp_pkg::PTR_W-1:0] out_post_head_ptr,
    input wire logic [mqp_pkg::PTR_W-1:0] out_free_tail_ptr,
    input wire logic [mqp_pkg::PTR_W-1:0] in_free_head_ptr
);
    import mqp_pkg::*;
    logic [31:0] sz, o_if, o_op;
    logic [11:0] bhi;
    logic [17:0] wf;
    // Hidden hardware pointers are recovered from qaddr, as they have no port of their own.
    assign sz = queue_size[4] ? 32'h00100000 : queue_size[3] ? 32'h00080000 :
        queue_size[2] ? 32'h00040000 : queue_size[1] ? 32'h00020000 : 32'h00010000;
    assign bhi = queue_base[31:20];
    assign wf = host_req.wdata[19:2] & (sz[19:2] - 18'h00001);
    assign o_if = qaddr.in_free - {bhi, 20'h00000};
    assign o_op = qaddr.out_post - {bhi, 20'h00000} - (sz << 1);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    AST_RST: assert property (disable iff (1'b0) sys_rst |=>
        host_rdata == 32'h0 && o_if == 32'h0) else $error("Not cleared by reset.");
    AST_RD_HEAD: assert property (host_req.rd && host_req.addr == 9'h0C8 |=>
        host_rdata == {$past(bhi), $past(in_free_head_ptr), 2'b00}) else $error("Bad head read.");
    AST_WR_MASK: assert property (host_req.wr && host_req.addr == 9'h0C8 |=>
        in_free_head_ptr == $past(wf)) else $error("Head write not masked.");
    AST_SW_HOLD: assert property (!host_req.wr && !local_req.wr |=>
        $stable(in_post_tail_ptr) && $stable(out_free_tail_ptr) && $stable(out_post_head_ptr))
        else $error("Software pointer moved.");
    AST_IF_STEP: assert property (step.in_free_take |=>
        o_if == (($past(o_if) + 32'h4) & (sz - 32'h1))) else $error("Free tail step wrong.");
    AST_OP_STEP: assert property (step.out_post_take ##1 $stable(queue_size) |->
        o_op == (($past(o_op) + 32'h4) & (sz - 32'h1))) else $error("Post tail step wrong.");
    AST_IF_HOLD: assert property (!step.in_free_take && !host_req.wr && !local_req.wr |=>
        $stable(o_if)) else $error("Free tail moved without cause.");
    AST_QADDR: assert property (o_if < sz && o_op < sz &&
        qaddr.in_free[31:20] == bhi) else $error("Queue address outside its region.");
    cover property (step.out_post_take);
    cover property (host_req.wr ##2 local_req.rd);
    cover property (o_if == 32'h0 && step.in_free_take);
endmodule
bind mqp_regs mqp_regs_props mqp_regs_props_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .host_req(host_req),
    .host_rdata(host_rdata),
    .local_req(local_req),
    .local_rdata(local_rdata),
    .queue_base(queue_base),
    .queue_size(queue_size),
    .step(step),
    .qaddr(qaddr),
    .in_post_tail_ptr(in_post_tail_ptr),
    .out_post_head_ptr(out_post_head_ptr),
    .out_free_tail_ptr(out_free_tail_ptr),
    .in_free_head_ptr(in_free_head_ptr)
);

// file: sim/tb.sv
// Self-checking testbench for the queue pointer register bank.
`timescale 1ns/1ns
module tb;
    import mqp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    mqp_req_t host_req = '0;
    mqp_req_t local_req = '0;
    mqp_step_t step = '0;
    logic [31:0] queue_base = 32'hABC00000;
    logic [4:0] queue_size = 5'h01;
    logic [31:0] host_rdata, local_rdata, rd, sz, b;
    mqp_addr_t qaddr;
    logic [PTR_W-1:0] in_post_tail_ptr, out_post_head_ptr, out_free_tail_ptr, in_free_head_ptr;
    int failures, total_checks;
    // Hardware pointers and their region multiple m; qaddr holds region m in slot 3 - m.
    logic [7:0] hw_ofs [4] = '{8'hCC, 8'hD0, 8'hD8, 8'hE4};
    int hw_mul [4] = '{0, 1, 3, 2};
    mqp_regs mqp_regs_i (
        .clk(clk),
        .sys_rst(sys_rst),
        .host_req(host_req),
        .host_rdata(host_rdata),
        .local_req(local_req),
        .local_rdata(local_rdata),
        .queue_base(queue_base),
        .queue_size(queue_size),
        .step(step),
        .qaddr(qaddr),
        .in_post_tail_ptr(in_post_tail_ptr),
        .out_post_head_ptr(out_post_head_ptr),
        .out_free_tail_ptr(out_free_tail_ptr),
        .in_free_head_ptr(in_free_head_ptr)
    );
    initial forever #4 clk = ~clk;
    initial begin
        #100000 failures++;
        wrap_up();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("Checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // One register access on either bus; local addresses sit 0x80 above the host ones.
    task automatic acc(input bit loc, input bit wr, input logic [8:0] a, input logic [31:0] d);
        mqp_req_t r;
        r = '{wr, !wr, loc ? a + 9'h080 : a, d};
        @(posedge clk);
        if (loc) local_req <= r;
        else host_req <= r;
        @(posedge clk);
        host_req <= '0;
        local_req <= '0;
        #1 rd = loc ? local_rdata : host_rdata;
    endtask
    task automatic reset_to(input logic [4:0] code, input logic [31:0] bytes);
        @(posedge clk);
        sys_rst <= 1'b1;
        queue_size <= code;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        sz = bytes;
        b = {queue_base[31:20], 20'h00000};
    endtask
    task automatic s_reset_values();
        acc(1'b1, 1'b1, 9'h0C4, 32'hFFFFFFFF);
        for (int i = 0; i < 8; i++) begin
            acc(i[0], 1'b0, 9'h0C8 + 9'(4 * i), 32'h0);
            chk(rd, b);
        end
        acc(1'b0, 1'b0, 9'h0C4, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic s_sw_write();
        for (int i = 0; i < 8; i++) begin
            acc(i[0], 1'b1, 9'h0C8 + 9'(4 * i), 32'hFFFFFFFF);
            acc(!i[0], 1'b0, 9'h0C8 + 9'(4 * i), 32'h0);
            chk(rd, b | ((sz - 32'h1) & 32'h000FFFFC));
        end
    endtask
    // Each hardware pointer starts on the last entry, so the first step must wrap.
    task automatic s_step(input logic [PTR_W-1:0] sw);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 1'b1, {1'b0, hw_ofs[i]}, sz - 32'h4);
            for (int k = 0; k < 2; k++) begin
                @(posedge clk);
                step <= mqp_step_t'(4'h8 >> i);
                @(posedge clk);
                step <= '0;
                #1 rd = qaddr[32 * (3 - hw_mul[i]) +: 32];
                chk(rd, b + sz * hw_mul[i] + 32'(4 * k));
                acc(k[0], 1'b0, {1'b0, hw_ofs[i]}, 32'h0);
                chk(rd, b + 32'(4 * k));
            end
        end
        chk({14'h0000, in_free_head_ptr}, {14'h0000, sw});
        chk({14'h0000, in_post_tail_ptr}, {14'h0000, sw});
        chk({14'h0000, out_post_head_ptr}, {14'h0000, sw});
        chk({14'h0000, out_free_tail_ptr}, {14'h0000, sw});
    endtask
    initial begin
        reset_to(5'h01, 32'h00010000);
        s_reset_values();
        s_sw_write();
        s_step(18'h03FFF);
        reset_to(5'h18, 32'h00100000);
        s_reset_values();
        s_step(18'h00000);
        wrap_up();
    end
endmodule

// file: verilog/mqp_pkg.sv
// Package for the message queue pointer register bank.
package mqp_pkg;

    // ======================================================================
    // Register offsets (byte addresses on the host side).
    // ======================================================================
    localparam logic [7:0] INBOUND_FREE_HEAD_OFS = 8'hC8;
    localparam logic [7:0] INBOUND_FREE_TAIL_OFS = 8'hCC;
    localparam logic [7:0] INBOUND_POST_HEAD_OFS = 8'hD0;
    localparam logic [7:0] INBOUND_POST_TAIL_OFS = 8'hD4;
    localparam logic [7:0] OUTBOUND_FREE_HEAD_OFS = 8'hD8;
    localparam logic [7:0] OUTBOUND_FREE_TAIL_OFS = 8'hDC;
    localparam logic [7:0] OUTBOUND_POST_HEAD_OFS = 8'hE0;
    localparam logic [7:0] OUTBOUND_POST_TAIL_OFS = 8'hE4;
    localparam logic [8:0] LOCAL_OFS_BASE = 9'h080;

    // ======================================================================
    // Field layout and reset values.
    // ======================================================================
    localparam int PTR_LSB = 2;
    localparam int PTR_MSB = 19;
    localparam int BASE_LSB = 20;
    localparam int PTR_W = PTR_MSB - PTR_LSB + 1;
    localparam logic [PTR_W-1:0] PTR_RST = 18'h00000;
    localparam logic [PTR_W-1:0] PTR_STEP = 18'h00001;
    localparam logic [4:0] QSIZE_RST = 5'h01;
    localparam logic [31:0] BAD_ADDR_DATA = 32'h00000000;

    // Queue selector inside the local memory region.
    typedef enum logic [1:0] {
        MQP_Q_IN_FREE = 2'h0,
        MQP_Q_IN_POST = 2'h1,
        MQP_Q_OUT_POST = 2'h2,
        MQP_Q_OUT_FREE = 2'h3
    } mqp_queue_t;

    // Register access request from one of the two buses.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [31:0] wdata;
    } mqp_req_t;

    // Hardware queue step strobes.
    typedef struct packed {
        logic in_free_take;
        logic in_post_put;
        logic out_free_put;
        logic out_post_take;
    } mqp_step_t;

    // Per-queue local memory addresses.
    typedef struct packed {
        logic [31:0] in_free;
        logic [31:0] in_post;
        logic [31:0] out_post;
        logic [31:0] out_free;
    } mqp_addr_t;

endpackage

// file: verilog/mqp_ptr.sv
// One queue pointer: software-written offset with optional hardware stepping.
`timescale 1ns/1ns
module mqp_ptr #(
    parameter bit HW_STEP = 1'b0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [mqp_pkg::PTR_W-1:0] wr_val,
    input wire logic step,
    input wire logic [mqp_pkg::PTR_W-1:0] wrap_mask,
    output logic [mqp_pkg::PTR_W-1:0] ptr
);
    import mqp_pkg::*;

    logic [PTR_W-1:0] ptr_r;
    logic [PTR_W-1:0] ptr_nxt;

    // A hardware step in the same cycle as a software write wins, so no
    // consumed or posted entry is forgotten.
    always_comb begin
        ptr_nxt = ptr_r;
        if (wr_en) begin
            ptr_nxt = wr_val & wrap_mask;
        end
        if (HW_STEP && step) begin
            ptr_nxt = (ptr_r + PTR_STEP) & wrap_mask;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ptr_r <= PTR_RST;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign ptr = ptr_r;
endmodule

// file: verilog/mqp_regs.sv
// Message queue pointer register bank, reachable from host and local bus.
//
// Notes on behaviour
// - Hardware steps inbound free tail per consumed entry, wrapping at queue size.
// - Hardware steps inbound post head per posted entry, wrapping at queue size.
// - Hardware steps outbound free head per returned entry, wrapping at queue size.
// - Hardware steps outbound post tail per taken entry, wrapping at queue size; all pointers reset zero.
// - Inbound free at base; inbound post at base plus one queue size.
// - Outbound post at base plus two queue sizes plus its tail.
// - Outbound free at base plus three queue sizes plus its head.
`timescale 1ns/1ns
module mqp_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire mqp_pkg::mqp_req_t host_req,
    output logic [31:0] host_rdata,
    input wire mqp_pkg::mqp_req_t local_req,
    output logic [31:0] local_rdata,
    input wire logic [31:0] queue_base,
    input wire logic [4:0] queue_size,
    input wire mqp_pkg::mqp_step_t step,
    output mqp_pkg::mqp_addr_t qaddr,
    output logic [mqp_pkg::PTR_W-1:0] in_post_tail_ptr,
    output logic [mqp_pkg::PTR_W-1:0] out_post_head_ptr,
    output logic [mqp_pkg::PTR_W-1:0] out_free_tail_ptr,
    output logic [mqp_pkg::PTR_W-1:0] in_free_head_ptr
);
    import mqp_pkg::*;

    // ======================================================================
    // Queue size decode.
    // ======================================================================
    // Size code 1 is 64 KB, doubling per higher set code bit up to 1 MB. One queue
    // then spans queue bytes; the pointer wraps inside it.
    // A size code of zero falls to the smallest queue, so a cleared size
    // field never leaves the pointers without a wrap point.
    logic [20:0] qbytes;
    logic [PTR_W:0] qents;
    logic [PTR_W-1:0] wrap_mask;

    always_comb begin
        if (queue_size[4]) begin
            qbytes = 21'h100000;
        end else if (queue_size[3]) begin
            qbytes = 21'h080000;
        end else if (queue_size[2]) begin
            qbytes = 21'h040000;
        end else if (queue_size[1]) begin
            qbytes = 21'h020000;
        end else begin
            qbytes = 21'h010000;
        end
        // One spare bit holds the 1 MB entry count, which overflows the field.
        qents = qbytes[PTR_MSB+1:PTR_LSB] - {1'b0, PTR_STEP};
        wrap_mask = qents[PTR_W-1:0];
    end

    // ======================================================================
    // Address decode. The local bus sees the bank at the host offset plus
    // a fixed displacement; host writes win over local writes in one cycle.
    // ======================================================================
    logic [7:0] wr_sel;
    logic [PTR_W-1:0] wr_val;

    function automatic logic [7:0] sel_of(input logic [8:0] a);
        logic [7:0] s;
        s = 8'h00;
        if (a == {1'b0, INBOUND_FREE_HEAD_OFS}) begin
            s[0] = 1'b1;
        end else if (a == {1'b0, INBOUND_FREE_TAIL_OFS}) begin
            s[1] = 1'b1;
        end else if (a == {1'b0, INBOUND_POST_HEAD_OFS}) begin
            s[2] = 1'b1;
        end else if (a == {1'b0, INBOUND_POST_TAIL_OFS}) begin
            s[3] = 1'b1;
        end else if (a == {1'b0, OUTBOUND_FREE_HEAD_OFS}) begin
            s[4] = 1'b1;
        end else if (a == {1'b0, OUTBOUND_FREE_TAIL_OFS}) begin
            s[5] = 1'b1;
        end else if (a == {1'b0, OUTBOUND_POST_HEAD_OFS}) begin
            s[6] = 1'b1;
        end else if (a == {1'b0, OUTBOUND_POST_TAIL_OFS}) begin
            s[7] = 1'b1;
        end
        return s;
    endfunction

    logic [8:0] local_host_addr;
    assign local_host_addr = local_req.addr - LOCAL_OFS_BASE;

    // A local write that meets a host write in the same cycle is lost, so
    // the two sides must not write to the bank at the same moment, even to different pointers.
    always_comb begin
        wr_sel = 8'h00;
        wr_val = PTR_RST;
        if (host_req.wr) begin
            wr_sel = sel_of(host_req.addr);
            wr_val = host_req.wdata[PTR_MSB:PTR_LSB];
        end else if (local_req.wr) begin
            wr_sel = sel_of(local_host_addr);
            wr_val = local_req.wdata[PTR_MSB:PTR_LSB];
        end
    end

    // ======================================================================
    // The eight pointers.
    // ======================================================================
    logic [PTR_W-1:0] ptr [8];
    logic [7:0] hw_step;

    // Index order matches wr_sel bit order.
    // Software-kept slots get a constant zero, so only a bus write moves them.
    assign hw_step = {step.out_post_take, 1'b0, 1'b0, step.out_free_put,
                      1'b0, step.in_post_put, step.in_free_take, 1'b0};

    // Indexes 0, 3, 5 and 6 are software-kept; the rest step in hardware.
    for (genvar i = 0; i < 8; i++) begin : g_ptr
        mqp_ptr #(
            .HW_STEP((i == 1) || (i == 2) || (i == 4) || (i == 7))
        ) u_ptr (
            .clk(clk),
            .sys_rst(sys_rst),
            .wr_en(wr_sel[i]),
            .wr_val(wr_val),
            .step(hw_step[i]),
            .wrap_mask(wrap_mask),
            .ptr(ptr[i])
        );
    end

    // ======================================================================
    // Read paths.
    // ======================================================================
    function automatic logic [31:0] rd_of(input logic [8:0] a);
        logic [7:0] s;
        logic [31:0] d;
        s = sel_of(a);
        d = BAD_ADDR_DATA;
        for (int k = 0; k < 8; k++) begin
            if (s[k]) begin
                // Low two bits read zero; top bits mirror the base.
                d = {queue_base[31:BASE_LSB], ptr[k], 2'b00};
            end
        end
        return d;
    endfunction

    // Each bus has its own read flop, so a read on one side never disturbs
    // the data that the other side is still looking at. The value holds
    // until the next read on that bus.
    logic [31:0] host_rdata_r;
    logic [31:0] host_rdata_nxt;
    logic [31:0] local_rdata_r;
    logic [31:0] local_rdata_nxt;

    always_comb begin
        host_rdata_nxt = host_rdata_r;
        local_rdata_nxt = local_rdata_r;
        if (host_req.rd) begin
            host_rdata_nxt = rd_of(host_req.addr);
        end
        if (local_req.rd) begin
            local_rdata_nxt = rd_of(local_host_addr);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_rdata_r <= BAD_ADDR_DATA;
            local_rdata_r <= BAD_ADDR_DATA;
        end else begin
            host_rdata_r <= host_rdata_nxt;
            local_rdata_r <= local_rdata_nxt;
        end
    end

    assign host_rdata = host_rdata_r;
    assign local_rdata = local_rdata_r;

    // ======================================================================
    // Queue entry addresses. Only the base bits above the 1 MB line count,
    // which is why misaligned bases are silently rounded down.
    // ======================================================================
    logic [31:0] base_al;
    logic [31:0] q1;
    logic [31:0] q2;
    logic [31:0] q3;
    logic [31:0] ofs_in_free;
    logic [31:0] ofs_in_post;
    logic [31:0] ofs_out_post;
    logic [31:0] ofs_out_free;
    assign base_al = {queue_base[31:BASE_LSB], 20'h00000};
    assign q1 = {11'h000, qbytes};
    // The four regions span at most 4 MB, so the doubled size cannot lose
    // its top bit.
    assign q2 = {q1[30:0], 1'b0};
    assign q3 = q2 + q1;

    // Pointer fields are put back at their byte position.
    assign ofs_in_free = {12'h000, ptr[1], 2'b00};
    assign ofs_in_post = {12'h000, ptr[2], 2'b00};
    assign ofs_out_post = {12'h000, ptr[7], 2'b00};
    assign ofs_out_free = {12'h000, ptr[4], 2'b00};

    always_comb begin
        qaddr.in_free = base_al + ofs_in_free;
        qaddr.in_post = base_al + q1 + ofs_in_post;
        qaddr.out_post = base_al + q2 + ofs_out_post;
        qaddr.out_free = base_al + q3 + ofs_out_free;
    end

    // Software-kept pointers, offered for full and empty comparison.
    // The queue logic outside compares them against the hardware pointers.
    assign in_free_head_ptr = ptr[0];
    assign in_post_tail_ptr = ptr[3];
    assign out_free_tail_ptr = ptr[5];
    assign out_post_head_ptr = ptr[6];
endmodule
